// ### rtl/smr_bank.sv
// Safety monitor register bank: watchdog seed and answer checking,
// window complement copies, on-demand self-test, self-test results,
// fault error counter and voltage monitor status.
// Assumes all inputs synchronous to clock; the window timer, analog
// self-test engine and monitors live outside and drive the inputs.
module smr_bank
   import smr_pkg::*;
#(
   parameter int OTP_WORDS = 4
) (
   // Clock, reset, enable
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Register port
   input wire smr_req_t req,
   output logic [15:0] reg_rdata,
   // Watchdog side
   input wire logic variant_inverted,
   input wire logic window_open,
   input wire logic wd_timeout,
   output logic refresh_good,
   output logic refresh_bad,
   output logic [3:0] window_duration,
   output logic [2:0] window_duty,
   // Analog self-test side
   output logic selftest_run,
   input wire logic selftest_done,
   input wire smr_analog_selftest_t selftest_result,
   input wire logic [OTP_WORDS*16-1:0] otp_config,
   input wire logic [15:0] otp_checksum,
   // Logic self-test and output pin checks
   input wire logic logic_selftest_done,
   input wire logic logic_selftest_ok,
   input wire logic [5:0] pin_stuck,
   // Fault counter and monitors
   input wire logic fault_event,
   output logic fault_limit_reached,
   input wire smr_mon_t mon_live
);

   // Additive checksum over the configuration words
   function automatic logic [15:0] otp_sum(input logic [OTP_WORDS*16-1:0] cfg);
      logic [15:0] s;
      s = SMR_ZERO16;
      for (int i = 0; i < OTP_WORDS; i++) begin
         s = s + cfg[i*16 +: 16];
      end
      return s;
   endfunction : otp_sum

   // Maximum count for a limit code
   function automatic logic [3:0] lim_max(input logic [1:0] code);
      case (code)
         2'b00: return SMR_LIM0;
         2'b01: return SMR_LIM1;
         2'b10: return SMR_LIM2;
         default: return SMR_LIM3;
      endcase
   endfunction : lim_max

   typedef enum logic [1:0] {ST_IDLE, ST_RUN} smr_st_t;

   logic [3:0] win_r, win_inv_r, win_app_r, flt_cnt_r;
   logic [2:0] duty_r, duty_inv_r, duty_app_r;
   logic [15:0] seed_r, answer_r, rdata_r;
   logic st_start_r, st_inv_r, run_r;
   smr_st_t st_state_r;
   smr_analog_selftest_t analog_selftest_r;
   logic [5:0] stuck_r;
   logic lb_ran_r, lb_pass_r, flt_clr_r, flt_clr_inv_r;
   logic [1:0] flt_lim_r, flt_lim_inv_r, flt_lim_app_r;
   smr_mon_t mon_lat_r, mon_live_r;
   logic bad_data_r, bad_timing_r, refresh_good_r, refresh_bad_r, limit_hit_r;
   logic wr_seed, wr_answer, seed_refused, answer_ok, st_launch;
   logic [15:0] expect_answer;

   // Decode of writes and the answer check
   assign wr_seed = req.wr && req.idx == SMR_IDX_SEED;
   assign wr_answer = req.wr && req.idx == SMR_IDX_ANSWER;
   assign seed_refused = (req.wdata == SMR_SEED_ONES) ||
                         (!variant_inverted && req.wdata == SMR_SEED_ZEROS);
   assign expect_answer = variant_inverted ? ~seed_r : seed_r;
   assign answer_ok = req.wdata == expect_answer;
   assign st_launch = st_state_r == ST_IDLE && st_start_r && st_inv_r == ~st_start_r;

   // Window settings and their complements
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         win_r <= 4'h0;
         duty_r <= 3'h0;
         win_inv_r <= 4'h0;
         duty_inv_r <= 3'h0;
      end else if (clk_en && req.wr) begin
         if (req.idx == SMR_IDX_WIN) begin
            win_r <= req.wdata[SMR_WIN_LSB +: 4];
            duty_r <= req.wdata[SMR_DUTY_LSB +: 3];
         end
         if (req.idx == SMR_IDX_WIN_INV) begin
            win_inv_r <= req.wdata[SMR_WIN_LSB +: 4];
            duty_inv_r <= req.wdata[SMR_DUTY_LSB +: 3];
         end
      end
   end

   // Applied window: a half-written pair keeps the old setting
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         win_app_r <= 4'h0;
         duty_app_r <= 3'h0;
      end else if (clk_en) begin
         if (win_r == ~win_inv_r) begin
            win_app_r <= win_r;
         end
         if (duty_r == ~duty_inv_r) begin
            duty_app_r <= duty_r;
         end
      end
   end

   // Seed and answer registers
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         seed_r <= SMR_SEED_RST;
         answer_r <= SMR_ZERO16;
      end else if (clk_en) begin
         if (wr_seed && !seed_refused) begin
            seed_r <= req.wdata;
         end
         if (wr_answer) begin
            answer_r <= req.wdata;
         end
      end
   end

   // Refresh evaluation; a flag event beats a same-cycle clear
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         bad_data_r <= 1'b0;
         bad_timing_r <= 1'b0;
         refresh_good_r <= 1'b0;
         refresh_bad_r <= 1'b0;
      end else if (clk_en) begin
         refresh_good_r <= wr_answer && answer_ok && window_open;
         refresh_bad_r <= (wr_answer && (!answer_ok || !window_open)) || wd_timeout;
         if (req.wr && req.idx == SMR_IDX_WD_STS) begin
            if (req.wdata[SMR_BAD_DATA_BIT]) bad_data_r <= 1'b0;
            if (req.wdata[SMR_BAD_TIMING_BIT]) bad_timing_r <= 1'b0;
         end
         if (wr_answer && !answer_ok) begin
            bad_data_r <= 1'b1;
         end
         if ((wr_answer && !window_open) || wd_timeout) begin
            bad_timing_r <= 1'b1;
         end
      end
   end

   // On-demand analog self-test start and complement
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_start_r <= 1'b0;
         st_inv_r <= 1'b0;
         st_state_r <= ST_IDLE;
         run_r <= 1'b0;
      end else if (clk_en) begin
         if (req.wr && req.idx == SMR_IDX_ST_INV) begin
            st_inv_r <= req.wdata[0];
         end
         case (st_state_r)
            ST_IDLE: begin
               if (st_launch) begin
                  st_state_r <= ST_RUN;
                  run_r <= 1'b1;
               end else if (req.wr && req.idx == SMR_IDX_ST_CTRL) begin
                  st_start_r <= req.wdata[0];
               end else if (st_start_r) begin
                  st_start_r <= 1'b0; // Mismatched request is dropped
               end
            end
            ST_RUN: begin
               if (selftest_done) begin
                  st_start_r <= 1'b0;
                  st_state_r <= ST_IDLE;
                  run_r <= 1'b0;
               end
            end
            default: st_state_r <= ST_IDLE;
         endcase
      end
   end

   // Analog self-test results captured at the end of a run
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         analog_selftest_r <= '0;
      end else if (clk_en && st_state_r == ST_RUN && selftest_done) begin
         analog_selftest_r.bandgap_check_fail <= selftest_result.bandgap_check_fail;
         analog_selftest_r.reg_uv_ov_fail <= selftest_result.reg_uv_ov_fail;
         analog_selftest_r.ext_uv_ov_fail <= selftest_result.ext_uv_ov_fail;
         analog_selftest_r.oscillator_check_fail <= selftest_result.oscillator_check_fail;
         analog_selftest_r.config_checksum_fail <= otp_sum(otp_config) != otp_checksum;
      end
   end

   // Pin stuck-at flags and logic self-test status
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         stuck_r <= 6'h00;
         lb_ran_r <= 1'b0;
         lb_pass_r <= 1'b0;
      end else if (clk_en) begin
         stuck_r <= stuck_r | pin_stuck;
         if (logic_selftest_done) begin
            lb_ran_r <= 1'b1;
            lb_pass_r <= logic_selftest_ok;
         end
      end
   end

   // Fault control, complement and applied limit
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         flt_clr_r <= 1'b0;
         flt_lim_r <= 2'b00;
         flt_clr_inv_r <= 1'b0;
         flt_lim_inv_r <= 2'b00;
         flt_lim_app_r <= 2'b00;
      end else if (clk_en) begin
         if (req.wr && req.idx == SMR_IDX_FLT) begin
            flt_clr_r <= req.wdata[SMR_FLT_CLR_BIT];
            flt_lim_r <= req.wdata[1:0];
         end else begin
            flt_clr_r <= 1'b0;
         end
         if (req.wr && req.idx == SMR_IDX_FLT_INV) begin
            flt_clr_inv_r <= req.wdata[SMR_FLT_CLR_BIT];
            flt_lim_inv_r <= req.wdata[1:0];
         end
         if (flt_lim_r == ~flt_lim_inv_r) begin
            flt_lim_app_r <= flt_lim_r;
         end
      end
   end

   // Fault counter: saturates at fifteen, clear wins over an event
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         flt_cnt_r <= 4'h0;
         limit_hit_r <= 1'b0;
      end else if (clk_en) begin
         if (flt_clr_r) begin
            flt_cnt_r <= 4'h0;
         end else if (fault_event && flt_cnt_r != SMR_CNT_MAX) begin
            flt_cnt_r <= flt_cnt_r + 4'h1;
         end
         limit_hit_r <= flt_cnt_r >= lim_max(flt_lim_app_r);
      end
   end

   // Monitor status: latched set beats write-one clear, live mirror
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mon_lat_r <= '0;
         mon_live_r <= '0;
      end else if (clk_en) begin
         mon_live_r <= mon_live;
         if (req.wr && req.idx == SMR_IDX_MON_LAT) begin
            mon_lat_r <= (mon_lat_r & ~smr_mon_t'(req.wdata[14:0])) | mon_live;
         end else begin
            mon_lat_r <= mon_lat_r | mon_live;
         end
      end
   end

   // Read data, registered; unmapped indices read zero
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= SMR_ZERO16;
      end else if (clk_en && req.rd) begin
         case (req.idx)
            SMR_IDX_WIN: rdata_r <= {win_r, 1'b0, duty_r, 8'h00};
            SMR_IDX_WIN_INV: rdata_r <= {win_inv_r, 1'b0, duty_inv_r, 8'h00};
            SMR_IDX_SEED: rdata_r <= seed_r;
            SMR_IDX_ANSWER: rdata_r <= answer_r;
            SMR_IDX_ST_CTRL: rdata_r <= {15'h0000, st_start_r};
            SMR_IDX_ST_INV: rdata_r <= {15'h0000, st_inv_r};
            SMR_IDX_ANALOG_SELFTEST: rdata_r <= {1'b0, analog_selftest_r};
            SMR_IDX_PINLB: rdata_r <= {2'b00, stuck_r, 6'h00, lb_ran_r, lb_pass_r && lb_ran_r};
            SMR_IDX_FLT: rdata_r <= {9'h000, flt_clr_r, flt_cnt_r, flt_lim_r};
            SMR_IDX_FLT_INV: rdata_r <= {9'h000, flt_clr_inv_r, 4'h0, flt_lim_inv_r};
            SMR_IDX_MON_LAT: rdata_r <= {1'b0, mon_lat_r};
            SMR_IDX_MON_LIVE: rdata_r <= {1'b0, mon_live_r};
            SMR_IDX_WD_STS: rdata_r <= {10'h000, bad_timing_r, bad_data_r, 4'h0};
            default: rdata_r <= SMR_ZERO16;
         endcase
      end
   end

   // Outputs straight from flops
   assign reg_rdata = rdata_r;
   assign refresh_good = refresh_good_r;
   assign refresh_bad = refresh_bad_r;
   assign window_duration = win_app_r;
   assign window_duty = duty_app_r;
   assign selftest_run = run_r;
   assign fault_limit_reached = limit_hit_r;

   // Refused seed value leaves the seed alone
   property p_seed_refused;
      @(posedge clock) disable iff (sys_rst)
      clk_en && wr_seed && seed_refused |=> seed_r == $past(seed_r);
   endproperty
   a_seed_refused: assert property (p_seed_refused) else $error("refused seed was stored");
   // Accepted seed value is stored
   property p_seed_taken;
      @(posedge clock) disable iff (sys_rst)
      clk_en && wr_seed && req.wdata != SMR_SEED_ONES && req.wdata != SMR_SEED_ZEROS |=> seed_r == $past(req.wdata);
   endproperty
   a_seed_taken: assert property (p_seed_taken) else $error("valid seed not stored");
   // Wrong answer raises the bad-answer flag next cycle
   property p_bad_data;
      @(posedge clock) disable iff (sys_rst)
      clk_en && wr_answer && req.wdata != (variant_inverted ? ~seed_r : seed_r) |=> bad_data_r && refresh_bad_r;
   endproperty
   a_bad_data: assert property (p_bad_data) else $error("wrong answer not flagged");
   // Good answer in an open window gives a good refresh, unless a timeout lands with it
   property p_good;
      @(posedge clock) disable iff (sys_rst)
      clk_en && wr_answer && window_open && !wd_timeout && req.wdata == (variant_inverted ? ~seed_r : seed_r)
      |=> refresh_good_r && !refresh_bad_r;
   endproperty
   a_good: assert property (p_good) else $error("good answer not accepted");
   // Timeout raises the bad-timing flag
   property p_timing;
      @(posedge clock) disable iff (sys_rst)
      clk_en && wd_timeout |=> bad_timing_r;
   endproperty
   a_timing: assert property (p_timing) else $error("timeout not flagged");
   // Applied window moves only with a matching complement
   property p_window;
      @(posedge clock) disable iff (sys_rst)
      clk_en && win_r != ~win_inv_r |=> $stable(win_app_r);
   endproperty
   a_window: assert property (p_window) else $error("window applied without complement");
   // Clear zeroes the counter and the clear bit drops after one cycle
   property p_clear;
      @(posedge clock) disable iff (sys_rst)
      clk_en && req.wr && req.idx == SMR_IDX_FLT && req.wdata[SMR_FLT_CLR_BIT]
      ##1 clk_en && !(req.wr && req.idx == SMR_IDX_FLT) |=> flt_cnt_r == 4'h0 && !flt_clr_r;
   endproperty
   a_clear: assert property (p_clear) else $error("fault counter clear failed");
   // Pass never shows without a completed run
   property p_pass;
      @(posedge clock) disable iff (sys_rst)
      clk_en && req.rd && req.idx == SMR_IDX_PINLB && !lb_ran_r |=> !rdata_r[SMR_LB_PASS_BIT];
   endproperty
   a_pass: assert property (p_pass) else $error("pass shown without run");
   // Latched monitor flag holds without a clear
   property p_latched;
      @(posedge clock) disable iff (sys_rst)
      clk_en && mon_lat_r.tsd && !(req.wr && req.idx == SMR_IDX_MON_LAT) |=> mon_lat_r.tsd;
   endproperty
   a_latched: assert property (p_latched) else $error("latched flag lost");
   // Self-test starts only with a matching complement
   property p_start;
      @(posedge clock) disable iff (sys_rst)
      clk_en && st_state_r == ST_IDLE && st_start_r && st_inv_r |=> st_state_r == ST_IDLE;
   endproperty
   a_start: assert property (p_start) else $error("self-test started without complement");

endmodule : smr_bank

// ### rtl/smr_pkg.sv
// Package for the safety monitor register bank: register indices,
// field positions, reset values and the packed carriers of the block.
// Assumes one clock domain and a simple indexed register port.
package smr_pkg;
   // Register indices on the register port (one 16-bit word each)
   localparam logic [3:0] SMR_IDX_WIN = 4'h0;
   localparam logic [3:0] SMR_IDX_WIN_INV = 4'h1;
   localparam logic [3:0] SMR_IDX_SEED = 4'h2;
   localparam logic [3:0] SMR_IDX_ANSWER = 4'h3;
   localparam logic [3:0] SMR_IDX_ST_CTRL = 4'h4;
   localparam logic [3:0] SMR_IDX_ST_INV = 4'h5;
   localparam logic [3:0] SMR_IDX_ANALOG_SELFTEST = 4'h6;
   localparam logic [3:0] SMR_IDX_PINLB = 4'h7;
   localparam logic [3:0] SMR_IDX_FLT = 4'h8;
   localparam logic [3:0] SMR_IDX_FLT_INV = 4'h9;
   localparam logic [3:0] SMR_IDX_MON_LAT = 4'hA;
   localparam logic [3:0] SMR_IDX_MON_LIVE = 4'hB;
   localparam logic [3:0] SMR_IDX_WD_STS = 4'hC;
   // Field positions
   localparam int SMR_WIN_LSB = 12;
   localparam int SMR_DUTY_LSB = 8;
   localparam int SMR_FLT_CLR_BIT = 6;
   localparam int SMR_FLT_CNT_LSB = 2;
   localparam int SMR_LB_RAN_BIT = 1;
   localparam int SMR_LB_PASS_BIT = 0;
   localparam int SMR_BAD_TIMING_BIT = 5;
   localparam int SMR_BAD_DATA_BIT = 4;
   // Values after reset, refused seed values and the fault counter ceiling
   localparam logic [15:0] SMR_SEED_RST = 16'h5AB2;
   localparam logic [15:0] SMR_SEED_ZEROS = 16'h0000;
   localparam logic [15:0] SMR_SEED_ONES = 16'hFFFF;
   localparam logic [15:0] SMR_ZERO16 = 16'h0000;
   localparam logic [3:0] SMR_CNT_MAX = 4'hF;
   // Fault counter maxima for limit codes 00..11
   localparam logic [3:0] SMR_LIM0 = 4'h1;
   localparam logic [3:0] SMR_LIM1 = 4'h2;
   localparam logic [3:0] SMR_LIM2 = 4'h6;
   localparam logic [3:0] SMR_LIM3 = 4'hC;

   // Monitor conditions, laid out as the status word bits 14..0
   typedef struct packed {
      logic [1:0] cur_lim; // [1] regulator two, [0] regulator one
      logic tsd;
      logic [5:0] uv;
      logic [5:0] ov;
   } smr_mon_t;

   // Analog self-test results, laid out as bits 14..0
   typedef struct packed {
      logic bandgap_check_fail;
      logic [3:0] reg_uv_ov_fail;
      logic [7:0] ext_uv_ov_fail;
      logic oscillator_check_fail;
      logic config_checksum_fail;
   } smr_analog_selftest_t;

   // Register access request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] idx;
      logic [15:0] wdata;
   } smr_req_t;
endpackage : smr_pkg

// ### tb/smr_bank_test.sv
// Self-checking bench for the safety monitor register bank.
// Assumes the bank answers reads one cycle after the strobe and that
// its assertions stand in its own body; no partner model is needed.
module smr_bank_test;
   timeunit 1ns;
   timeprecision 1ps;
   import smr_pkg::*;

   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   smr_req_t req = '0;
   logic [15:0] reg_rdata;
   logic variant_inverted = 1'b0;
   logic window_open = 1'b1;
   logic wd_timeout = 1'b0;
   logic refresh_good, refresh_bad, selftest_run, fault_limit_reached;
   logic [3:0] window_duration;
   logic [2:0] window_duty;
   logic selftest_done = 1'b0;
   smr_analog_selftest_t selftest_result = '0;
   logic [63:0] otp_config = {16'h0004, 16'h0003, 16'h0002, 16'h0001};
   logic [15:0] otp_checksum = 16'h000B;
   logic logic_selftest_done = 1'b0;
   logic logic_selftest_ok = 1'b0;
   logic [5:0] pin_stuck = 6'h00;
   logic fault_event = 1'b0;
   smr_mon_t mon_live = '0;
   int n_mismatch = 0;
   int n_tests = 0;
   logic [15:0] rdat;

   // Clock at 50 MHz
   always #10 clock = ~clock;

   smr_bank #(.OTP_WORDS(4)) dut (
      .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .req(req), .reg_rdata(reg_rdata),
      .variant_inverted(variant_inverted), .window_open(window_open), .wd_timeout(wd_timeout),
      .refresh_good(refresh_good), .refresh_bad(refresh_bad), .window_duration(window_duration),
      .window_duty(window_duty), .selftest_run(selftest_run), .selftest_done(selftest_done),
      .selftest_result(selftest_result), .otp_config(otp_config), .otp_checksum(otp_checksum),
      .logic_selftest_done(logic_selftest_done), .logic_selftest_ok(logic_selftest_ok),
      .pin_stuck(pin_stuck), .fault_event(fault_event), .fault_limit_reached(fault_limit_reached),
      .mon_live(mon_live)
   );

   // Verdict and end of run, shared with the watchdog
   task end_of_test;
      if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test

   task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // One write strobe; effects land at the edge where the task returns
   task wr(input logic [3:0] idx, input logic [15:0] d);
      @(posedge clock);
      req <= '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: d};
      @(posedge clock);
      req <= '0;
   endtask : wr

   // Read strobe, data sampled mid-cycle after the taking edge
   task rchk(input logic [3:0] idx, input logic [15:0] exp, input string what);
      @(posedge clock);
      req <= '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 16'h0000};
      @(posedge clock);
      req <= '0;
      @(negedge clock);
      chk(reg_rdata, exp, what);
   endtask : rchk

   task fev(input int n);
      repeat (n) begin
         @(posedge clock);
         fault_event <= 1'b1;
         @(posedge clock);
         fault_event <= 1'b0;
      end
   endtask : fev

   // Seed reset value and refused values in both variants
   task t_seed;
      rchk(SMR_IDX_SEED, 16'h5AB2, "seed after reset");
      // A write while the enable is low must leave the seed alone
      @(posedge clock);
      clk_en <= 1'b0;
      wr(SMR_IDX_SEED, 16'h1111);
      clk_en <= 1'b1;
      rchk(SMR_IDX_SEED, 16'h5AB2, "enable low freezes seed");
      wr(SMR_IDX_SEED, 16'hFFFF);
      wr(SMR_IDX_SEED, 16'h0000);
      rchk(SMR_IDX_SEED, 16'h5AB2, "simple seed refusal");
      rchk(SMR_IDX_WIN, 16'h0000, "refusal leaves others");
      variant_inverted <= 1'b1;
      wr(SMR_IDX_SEED, 16'hFFFF);
      rchk(SMR_IDX_SEED, 16'h5AB2, "inverted seed refusal");
      wr(SMR_IDX_SEED, 16'h0000);
      rchk(SMR_IDX_SEED, 16'h0000, "inverted accepts zeros");
   endtask : t_seed

   // Window settings apply only with a matching complement
   task t_window;
      wr(SMR_IDX_WIN, 16'h5200);
      repeat (3) @(negedge clock);
      chk({9'h000, window_duration, window_duty}, 16'h0000, "window before match");
      wr(SMR_IDX_WIN_INV, 16'hA500);
      repeat (3) @(negedge clock);
      chk({9'h000, window_duration, window_duty}, 16'h002A, "window applied");
      rchk(SMR_IDX_WIN_INV, 16'hA500, "complement copy");
      wr(SMR_IDX_WIN, 16'h7200);
      repeat (3) @(negedge clock);
      chk({9'h000, window_duration, window_duty}, 16'h002A, "mismatch keeps window");
   endtask : t_window

   // Answer checking in both variants, closed window and timeout
   task t_answer;
      variant_inverted <= 1'b0;
      wr(SMR_IDX_SEED, 16'h1234);
      wr(SMR_IDX_ANSWER, 16'h1234);
      @(negedge clock);
      chk({14'h0000, refresh_good, refresh_bad}, 16'h0002, "simple good answer");
      wr(SMR_IDX_ANSWER, 16'hEDCB);
      @(negedge clock);
      chk({14'h0000, refresh_good, refresh_bad}, 16'h0001, "simple wrong answer");
      rchk(SMR_IDX_WD_STS, 16'h0010, "bad answer flag");
      wr(SMR_IDX_WD_STS, 16'h0030);
      variant_inverted <= 1'b1;
      wr(SMR_IDX_ANSWER, 16'hEDCB);
      @(negedge clock);
      chk({14'h0000, refresh_good, refresh_bad}, 16'h0002, "inverted good answer");
      wr(SMR_IDX_ANSWER, 16'h1234);
      @(negedge clock);
      chk({14'h0000, refresh_good, refresh_bad}, 16'h0001, "inverted wrong answer");
      window_open <= 1'b0;
      wr(SMR_IDX_ANSWER, 16'hEDCB);
      @(negedge clock);
      chk({14'h0000, refresh_good, refresh_bad}, 16'h0001, "closed window answer");
      rchk(SMR_IDX_WD_STS, 16'h0030, "both flags");
      wr(SMR_IDX_WD_STS, 16'h0030);
      window_open <= 1'b1;
      @(posedge clock);
      wd_timeout <= 1'b1;
      @(posedge clock);
      wd_timeout <= 1'b0;
      rchk(SMR_IDX_WD_STS, 16'h0020, "timeout flag");
   endtask : t_answer

   // Refused start, then two runs with bad and good configuration sum
   task t_selftest;
      int w;
      wr(SMR_IDX_ST_INV, 16'h0001);
      wr(SMR_IDX_ST_CTRL, 16'h0001);
      repeat (4) @(negedge clock);
      chk({15'h0000, selftest_run}, 16'h0000, "start without complement");
      wr(SMR_IDX_ST_INV, 16'h0000);
      for (int i = 0; i < 2; i++) begin
         otp_checksum <= 16'h000B - 16'(i);
         selftest_result <= (i == 0) ? 15'h2AAA : 15'h5555;
         wr(SMR_IDX_ST_CTRL, 16'h0001);
         w = 0;
         while (selftest_run !== 1'b1 && w < 8) begin
            @(negedge clock);
            w++;
         end
         chk({15'h0000, selftest_run}, 16'h0001, "self-test running");
         @(posedge clock);
         selftest_done <= 1'b1;
         @(posedge clock);
         selftest_done <= 1'b0;
         @(negedge clock);
         chk({15'h0000, selftest_run}, 16'h0000, "self-test ended");
         rchk(SMR_IDX_ST_CTRL, 16'h0000, "start bit self-cleared");
         rchk(SMR_IDX_ANALOG_SELFTEST, (i == 0) ? 16'h2AAB : 16'h5554, "analog result");
      end
   endtask : t_selftest

   // Logic self-test outcome and pin stuck flags
   task t_logic;
      rchk(SMR_IDX_PINLB, 16'h0000, "not run");
      for (int i = 0; i < 2; i++) begin
         @(posedge clock);
         logic_selftest_done <= 1'b1;
         logic_selftest_ok <= i[0];
         pin_stuck <= 6'h29;
         @(posedge clock);
         logic_selftest_done <= 1'b0;
         pin_stuck <= 6'h00;
         rchk(SMR_IDX_PINLB, 16'h2902 | 16'(i), "logic and pins");
      end
   endtask : t_logic

   // Every limit code, clear, count and saturation
   task t_fault;
      logic [3:0] lim [4];
      lim = '{SMR_LIM0, SMR_LIM1, SMR_LIM2, SMR_LIM3};
      for (int c = 0; c < 4; c++) begin
         wr(SMR_IDX_FLT_INV, {14'h0000, ~c[1:0]});
         wr(SMR_IDX_FLT, {9'h000, 1'b1, 4'h0, c[1:0]});
         rchk(SMR_IDX_FLT, {14'h0000, c[1:0]}, "cleared, clear bit gone");
         rchk(SMR_IDX_FLT_INV, {14'h0000, ~c[1:0]}, "complement held");
         fev(int'(lim[c]) - 1);
         repeat (2) @(negedge clock);
         chk({15'h0000, fault_limit_reached}, 16'h0000, "below limit");
         fev(1);
         repeat (2) @(negedge clock);
         chk({15'h0000, fault_limit_reached}, 16'h0001, "limit reached");
         rchk(SMR_IDX_FLT, {10'h000, lim[c], c[1:0]}, "count value");
      end
      fev(6);
      rchk(SMR_IDX_FLT, 16'h003F, "count saturates");
   endtask : t_fault

   // Latched flags hold after the condition goes, live copy follows
   task t_monitor;
      @(posedge clock);
      mon_live <= 15'h7041;
      rchk(SMR_IDX_MON_LIVE, 16'h7041, "live present");
      mon_live <= 15'h0000;
      rchk(SMR_IDX_MON_LIVE, 16'h0000, "live gone");
      rchk(SMR_IDX_MON_LAT, 16'h7041, "latched held");
      wr(SMR_IDX_MON_LAT, 16'h7041);
      rchk(SMR_IDX_MON_LAT, 16'h0000, "latched cleared");
   endtask : t_monitor

   // Main sequence
   initial begin
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      t_seed();
      t_window();
      t_answer();
      t_selftest();
      t_logic();
      t_fault();
      t_monitor();
      end_of_test();
   end

   // Hang guard, well beyond the few hundred cycles the tests take
   initial begin
      #200000;
      n_mismatch++;
      end_of_test();
   end
endmodule : smr_bank_test
